/* cct_timer.sv */
// Two-channel 16-bit capture/compare timer with an AXI4-Lite register slave.
// Functional notes
// - Register A compare mode: 000 none, 001 low, 010 high, 011 toggle on match.
// - Register A capture mode: 100 rising, 101 falling, 11X both edges copy counter.
// - Channel C/D control picks compare or capture for registers C and D.
// - Channel C/D control also sets function of timer pins C and D.
// - Bits 6..4 in compare mode: 000 none, 001 low, 010 high, 011 toggle.
// - Bits 6..4 in capture mode: 100 rising, 101 falling, 11X both edges.
// - Bits 7 and 3 of the C/D control register always read as one.
// - After reset both counters are stopped, and run free once started until a clear source is chosen.
// - A counter increments only while its start bit is one.
// - Overflow sets the overflow flag; interrupt when overflow enable is one.
// - After overflow the counter keeps counting from zero.
// - Clear select bits choose compare-match clearing for periodic counting.
// - Counter equal to a general register sets its flag, clears if source.
// - Match interrupt raised when flag sets with its enable bit one.
// - Master output enable bit at one stops timer drive of the pin.
// - Outputs are disabled or inverted by master enable, output control, external level.
// - Each channel has a 16-bit counter and four general registers.
`timescale 1ns/1ps
`default_nettype none
module cct_timer
    import cct_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [CCT_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [CCT_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [CCT_PIN_NUM-1:0] timer_pin_in,
    input wire logic output_disable_in,
    output logic [CCT_PIN_NUM-1:0] timer_pin_out,
    output logic [CCT_PIN_NUM-1:0] timer_pin_oe,
    output logic irq
);
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
        merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    endfunction

    cct_wreq_t wreq_q;
    logic aw_full_q;
    logic w_full_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    cct_chan_cfg_t cfg_q [CCT_CH_NUM];
    logic [CCT_CNT_W-1:0] cnt_q [CCT_CH_NUM];
    logic [CCT_CNT_W-1:0] gr_q [CCT_PIN_NUM];
    logic [CCT_PIN_NUM-1:0] level_q;
    logic [CCT_PIN_NUM-1:0] prev_q;
    logic [CCT_CH_NUM-1:0] start_q;
    logic [15:0] status_q;
    logic [15:0] irq_en_q;
    logic [7:0] out_master_q;
    logic [7:0] out_ctrl_q;

    logic [15:0] status_set;
    logic [31:0] rmap [32];

    // Write path: address and data are held separately so either may come first.
    wire wr_fire = aw_full_q & w_full_q & ~bvalid_q;
    wire [4:0] widx = wreq_q.addr[6:2];
    wire wmapped = ~wreq_q.addr[7] & (widx < 5'(CCT_REG_NUM));
    wire [31:0] wdat = wreq_q.data;
    wire [3:0] wstb = wreq_q.strb;
    logic [31:0] we;
    assign we = wr_fire & ~wreq_q.addr[7] ? (32'h1 << widx) : 32'h0;

    assign s_axi_awready = ~aw_full_q;
    assign s_axi_wready = ~w_full_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= CCT_AXI_OKAY;
            wreq_q <= '0;
        end else begin
            if (s_axi_awvalid && !aw_full_q) begin
                aw_full_q <= 1'b1;
                wreq_q.addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_q <= 1'b0;
            end
            if (s_axi_wvalid && !w_full_q) begin
                w_full_q <= 1'b1;
                wreq_q.data <= s_axi_wdata;
                wreq_q.strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full_q <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wmapped ? CCT_AXI_OKAY : CCT_AXI_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read path: one outstanding read, answered the cycle after the address is taken.
    wire [4:0] ridx = s_axi_araddr[6:2];
    wire rmapped = ~s_axi_araddr[7] & (ridx < 5'(CCT_REG_NUM));
    wire ar_take = s_axi_arvalid & ~rvalid_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= CCT_AXI_OKAY;
            rdata_q <= 32'h0;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rresp_q <= rmapped ? CCT_AXI_OKAY : CCT_AXI_SLVERR;
            rdata_q <= rmapped ? rmap[ridx] : 32'h0;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    genvar c;
    genvar g;
    generate
        for (c = 0; c < CCT_CH_NUM; c++) begin : g_ch
            localparam logic [4:0] BASE = 5'(c) * CCT_IDX_CH_STRIDE;
            localparam int SB = c * CCT_STAT_CH_STRIDE;
            logic [CCT_GR_NUM-1:0] match;
            logic [CCT_GR_NUM-1:0] capture;
            wire run = start_q[c];
            wire [1:0] csel = cfg_q[c].clr_sel;
            // Clear select 00 leaves the counter free running; 01..11 pick register A..C.
            wire clr = (csel != 2'h0) & match[csel - 2'h1];
            wire ovf = run & ~clr & (cnt_q[c] == {CCT_CNT_W{1'b1}});
            wire [CCT_CNT_W-1:0] cnt_d = we[BASE + CCT_IDX_CNT] ?
                merge16(cnt_q[c], wdat, wstb) :
                (run ? (clr ? '0 : cnt_q[c] + 16'h0001) : cnt_q[c]);

            assign rmap[BASE + CCT_IDX_CTRL] = {30'h0, cfg_q[c].clr_sel};
            assign rmap[BASE + CCT_IDX_IO_AB] = {24'h0, cfg_q[c].io_ab};
            assign rmap[BASE + CCT_IDX_IO_CD] = {24'h0, cfg_q[c].io_cd | CCT_IO_CD_ONES};
            assign rmap[BASE + CCT_IDX_CNT] = {16'h0, cnt_q[c]};
            assign status_set[SB + CCT_OVF_POS] = ovf;
            assign status_set[SB + CCT_STAT_CH_STRIDE - 1 : SB + CCT_OVF_POS + 1] = '0;

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cfg_q[c] <= {CCT_CLR_SEL_RST, CCT_IO_RST, CCT_IO_RST};
                    cnt_q[c] <= '0;
                end else begin
                    cnt_q[c] <= cnt_d;
                    if (we[BASE + CCT_IDX_CTRL] && wstb[0]) begin
                        cfg_q[c].clr_sel <= wdat[1:0];
                    end
                    if (we[BASE + CCT_IDX_IO_AB] && wstb[0]) begin
                        cfg_q[c].io_ab <= wdat[7:0];
                    end
                    if (we[BASE + CCT_IDX_IO_CD] && wstb[0]) begin
                        cfg_q[c].io_cd <= wdat[7:0] & ~CCT_IO_CD_ONES;
                    end
                end
            end

            for (g = 0; g < CCT_GR_NUM; g++) begin : g_gr
                localparam int P = c * CCT_GR_NUM + g;
                localparam int FPOS = (g % 2 == 0) ? CCT_IO_LO_POS : CCT_IO_HI_POS;
                // Registers A and B take their select from the A/B control, C and D
                // from the C/D control, which also settles the pins of C and D.
                wire [2:0] sel = (g < 2) ? cfg_q[c].io_ab[FPOS +: CCT_IO_SEL_W]
                                         : cfg_q[c].io_cd[FPOS +: CCT_IO_SEL_W];
                wire is_cap = sel[2];
                wire rise = timer_pin_in[P] & ~prev_q[P];
                wire fall = ~timer_pin_in[P] & prev_q[P];
                // Match is only looked at while counting, so a stopped counter does not
                // keep toggling a pin or refiring the flag every cycle.
                assign match[g] = ~is_cap & run & (cnt_q[c] == gr_q[P]);
                assign capture[g] = is_cap & (sel[1] ? (rise | fall) :
                                              (sel[0] ? fall : rise));
                assign status_set[SB + g] = match[g] | capture[g];
                assign rmap[BASE + CCT_IDX_GR + 5'(g)] = {16'h0, gr_q[P]};

                logic level_d;
                always_comb begin
                    level_d = level_q[P];
                    if (match[g]) begin
                        case (sel[1:0])
                            2'b01: level_d = 1'b0;
                            2'b10: level_d = 1'b1;
                            2'b11: level_d = ~level_q[P];
                            default: level_d = level_q[P];
                        endcase
                    end
                end

                // Pin drives only in compare mode and while neither the master
                // enable register nor the external level switches it off.
                assign timer_pin_oe[P] = ~is_cap & ~out_master_q[P] & ~output_disable_in;
                assign timer_pin_out[P] = timer_pin_oe[P] & (level_q[P] ^ out_ctrl_q[P]);

                always_ff @(posedge aclk) begin
                    if (!aresetn) begin
                        gr_q[P] <= CCT_GR_RST;
                        level_q[P] <= 1'b0;
                        prev_q[P] <= 1'b0;
                    end else begin
                        prev_q[P] <= timer_pin_in[P];
                        level_q[P] <= level_d;
                        if (capture[g]) begin
                            gr_q[P] <= cnt_q[c];
                        end else if (we[BASE + CCT_IDX_GR + 5'(g)]) begin
                            gr_q[P] <= merge16(gr_q[P], wdat, wstb);
                        end
                    end
                end
            end
        end
        for (c = CCT_REG_NUM; c < 32; c++) begin : g_unmapped
            assign rmap[c] = 32'h0;
        end
    endgenerate

    assign rmap[CCT_IDX_START] = {30'h0, start_q};
    assign rmap[CCT_IDX_STATUS] = {16'h0, status_q};
    assign rmap[CCT_IDX_CLEAR] = 32'h0;
    assign rmap[CCT_IDX_IRQ_EN] = {16'h0, irq_en_q};
    assign rmap[CCT_IDX_OUT_MASTER] = {24'h0, out_master_q};
    assign rmap[CCT_IDX_OUT_CTRL] = {24'h0, out_ctrl_q};

    // A hardware event in the same cycle as a software clear keeps its flag set.
    wire [15:0] clr_mask = we[CCT_IDX_CLEAR] ? merge16(16'h0, wdat, wstb) : 16'h0;
    wire [15:0] status_d = (status_q & ~clr_mask) | status_set;

    assign irq = |(status_q & irq_en_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_q <= '0;
            status_q <= '0;
            irq_en_q <= '0;
            out_master_q <= CCT_OUT_MASTER_RST;
            out_ctrl_q <= CCT_OUT_CTRL_RST;
        end else begin
            status_q <= status_d;
            if (we[CCT_IDX_START] && wstb[0]) begin
                start_q <= wdat[1:0];
            end
            if (we[CCT_IDX_IRQ_EN]) begin
                irq_en_q <= merge16(irq_en_q, wdat, wstb);
            end
            if (we[CCT_IDX_OUT_MASTER] && wstb[0]) begin
                out_master_q <= wdat[7:0];
            end
            if (we[CCT_IDX_OUT_CTRL] && wstb[0]) begin
                out_ctrl_q <= wdat[7:0];
            end
        end
    end
endmodule // cct_timer
`default_nettype wire

/* cct_pkg.sv */
// Package with register map, field layout, reset values and types of the capture/compare timer.
`default_nettype none
package cct_pkg;
    localparam int CCT_CH_NUM = 2;
    localparam int CCT_GR_NUM = 4;
    localparam int CCT_PIN_NUM = 8;
    localparam int CCT_CNT_W = 16;
    localparam int CCT_ADDR_W = 8;
    localparam int CCT_REG_NUM = 22;
    // Word indices; byte address is four times the index.
    localparam logic [4:0] CCT_IDX_CTRL = 5'h00;
    localparam logic [4:0] CCT_IDX_IO_AB = 5'h01;
    localparam logic [4:0] CCT_IDX_IO_CD = 5'h02;
    localparam logic [4:0] CCT_IDX_CNT = 5'h03;
    localparam logic [4:0] CCT_IDX_GR = 5'h04;
    localparam logic [4:0] CCT_IDX_CH_STRIDE = 5'h08;
    localparam logic [4:0] CCT_IDX_START = 5'h10;
    localparam logic [4:0] CCT_IDX_STATUS = 5'h11;
    localparam logic [4:0] CCT_IDX_CLEAR = 5'h12;
    localparam logic [4:0] CCT_IDX_IRQ_EN = 5'h13;
    localparam logic [4:0] CCT_IDX_OUT_MASTER = 5'h14;
    localparam logic [4:0] CCT_IDX_OUT_CTRL = 5'h15;
    // Field positions.
    localparam int CCT_IO_LO_POS = 0;
    localparam int CCT_IO_HI_POS = 4;
    localparam int CCT_IO_SEL_W = 3;
    localparam int CCT_OVF_POS = 4;
    localparam int CCT_STAT_CH_STRIDE = 8;
    // Reset values and read-as-one mask of the C/D control register.
    localparam logic [1:0] CCT_CLR_SEL_RST = 2'h0;
    localparam logic [7:0] CCT_IO_RST = 8'h00;
    localparam logic [7:0] CCT_IO_CD_ONES = 8'h88;
    localparam logic [15:0] CCT_GR_RST = 16'hFFFF;
    localparam logic [7:0] CCT_OUT_MASTER_RST = 8'hFF;
    localparam logic [7:0] CCT_OUT_CTRL_RST = 8'h00;
    localparam logic [1:0] CCT_AXI_OKAY = 2'h0;
    localparam logic [1:0] CCT_AXI_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] clr_sel;
        logic [7:0] io_ab;
        logic [7:0] io_cd;
    } cct_chan_cfg_t;

    typedef struct packed {
        logic [CCT_ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } cct_wreq_t;
endpackage
`default_nettype wire

/* cct_timer_asserts.sv */
// Checker with bus, pin and interrupt assertions of the capture/compare timer.
`timescale 1ns/1ps
`default_nettype none
module cct_timer_asserts
    import cct_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic output_disable_in,
    input wire logic [CCT_PIN_NUM-1:0] timer_pin_out,
    input wire logic [CCT_PIN_NUM-1:0] timer_pin_oe,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_PIN_OFF: assert property ((timer_pin_out & ~timer_pin_oe) == 8'h00)
        else $error("pin level shown on an undriven pin");
    AST_EXT_DIS: assert property (output_disable_in |-> timer_pin_oe == 8'h00)
        else $error("pin driven while external disable is high");
    AST_AR_RDY: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready not the inverse of read valid");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_RV_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    AST_BV_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
        else $error("write response timing wrong");
    // A flag only leaves through a register write, so irq may only fall as a write completes.
    AST_IRQ_FALL: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
        else $error("interrupt fell without a register write");
endmodule // cct_timer_asserts
`default_nettype wire

/* cct_pin_model.sv */
// Model of the outside circuit that shares the timer pins.
`timescale 1ns/1ps
`default_nettype none
module cct_pin_model
    import cct_pkg::*;
(
    input wire logic [CCT_PIN_NUM-1:0] pin_out,
    input wire logic [CCT_PIN_NUM-1:0] pin_oe,
    input wire logic [CCT_PIN_NUM-1:0] ext_level,
    output logic [CCT_PIN_NUM-1:0] pin_level
);
    // The outside driver yields a pin while the timer drives it, so no contention is modelled.
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // cct_pin_model
`default_nettype wire

/* cct_timer_bench.sv */
// Self-checking testbench of the capture/compare timer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module cct_timer_bench
    import cct_pkg::*;
();
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, odis;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0] awaddr, araddr, p_out, p_oe, p_in, ext;
    logic [31:0] wdata, rdata, v, c1;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;
    cct_timer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_pin_in(p_in),
        .output_disable_in(odis), .timer_pin_out(p_out), .timer_pin_oe(p_oe), .irq(irq));
    cct_pin_model i_pins (.pin_out(p_out), .pin_oe(p_oe), .ext_level(ext), .pin_level(p_in));
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            tally_and_finish();
        end
    end
    // Ready is looked at on the falling edge, where it has settled, and acted on at the next rise.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, da, dw;
        da = 1'b0;
        dw = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(da && dw)) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            da = da | ta;
            dw = dw | tw;
        end
        do @(negedge aclk); while (!bvalid);
        rsp = bresp;
        @(posedge aclk);
        bready <= 1'b1;
        @(posedge aclk);
        bready <= 1'b0;
        @(negedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        d = rdata;
        rsp = rresp;
        @(posedge aclk);
        rready <= 1'b1;
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        rd(a, v);
        `CHK(nm, e, v)
    endtask
    task automatic wait_irq(input int lim);
        for (int n = 0; n < lim && irq !== 1'b1; n++) @(negedge aclk);
    endtask
    task automatic edge_chk(input logic [7:0] lvl, input logic [31:0] e, input string nm);
        @(posedge aclk);
        ext <= lvl;
        repeat (3) @(posedge aclk);
        chk_rd(8'h44, e, nm);
        wr(8'h48, 32'h00001F1F);
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, odis} = 7'h00;
        {awaddr, araddr, ext, wstrb} = 28'h0000000;
        wdata = 32'h00000000;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        chk_rd(8'h08, 32'h00000088, "io_cd_reset");
        chk_rd(8'h50, 32'h000000FF, "master_reset");
        chk_rd(8'h10, 32'h0000FFFF, "gr_a_reset");
        chk_rd(8'h7C, 32'h00000000, "unmapped_data");
        `CHK("unmapped_resp", CCT_AXI_SLVERR, rsp)
        wr(8'h7C, 32'h00000001);
        `CHK("unmapped_wresp", CCT_AXI_SLVERR, rsp)
        wr(8'h08, 32'h00000077);
        `CHK("mapped_wresp", CCT_AXI_OKAY, rsp)
        chk_rd(8'h08, 32'h000000FF, "io_cd_ones");
        chk_rd(8'h2C, 32'h00000000, "cnt1_idle");
        $display("test registers done");
        wr(8'h10, 32'h00000100);
        wr(8'h00, 32'h00000001);
        wr(8'h04, 32'h00000003);
        wr(8'h50, 32'h00000000);
        wr(8'h4C, 32'h00000001);
        `CHK("oe_a", 1'b1, p_oe[0])
        `CHK("pin_a_start", 1'b0, p_out[0])
        wr(8'h40, 32'h00000001);
        wait_irq(400);
        wr(8'h40, 32'h00000000);
        `CHK("irq_match", 1'b1, irq)
        `CHK("pin_a_toggled", 1'b1, p_out[0])
        rd(8'h0C, c1);
        `CHK("cnt_cleared", 1'b1, c1 < 32'h00000010)
        chk_rd(8'h0C, c1, "cnt_stopped");
        chk_rd(8'h44, 32'h00000001, "flag_a");
        wr(8'h54, 32'h00000001);
        `CHK("pin_a_inv", 1'b0, p_out[0])
        @(posedge aclk);
        odis <= 1'b1;
        @(negedge aclk);
        `CHK("oe_ext", 8'h00, p_oe)
        @(posedge aclk);
        odis <= 1'b0;
        wr(8'h50, 32'h000000FF);
        `CHK("oe_master", 8'h00, p_oe)
        `CHK("irq_held", 1'b1, irq)
        wr(8'h48, 32'h00000001);
        `CHK("irq_clear", 1'b0, irq)
        $display("test compare done");
        wr(8'h00, 32'h00000000);
        wr(8'h4C, 32'h00000010);
        wr(8'h0C, 32'h0000FFF0);
        wr(8'h40, 32'h00000001);
        wait_irq(100);
        wr(8'h40, 32'h00000000);
        // Passing FFFF also matches register B, which still holds its reset value.
        chk_rd(8'h44, 32'h00000012, "flag_ovf");
        rd(8'h0C, c1);
        `CHK("cnt_wrapped", 1'b1, c1 < 32'h00000010)
        wr(8'h48, 32'h000000FF);
        $display("test overflow done");
        wr(8'h08, 32'h00000040);
        wr(8'h40, 32'h00000001);
        edge_chk(8'h08, 32'h00000008, "cap_d_rise");
        rd(8'h1C, c1);
        `CHK("gr_d_captured", 1'b1, c1 < 32'h00000100)
        edge_chk(8'h00, 32'h00000000, "cap_d_fall");
        wr(8'h40, 32'h00000000);
        for (int k = 4; k < 8; k++) begin
            wr(8'h24, 32'(k));
            edge_chk(8'h10, (k != 5) ? 32'h00000100 : 32'h00000000, "cap_a_rise");
            edge_chk(8'h00, (k != 4) ? 32'h00000100 : 32'h00000000, "cap_a_fall");
        end
        $display("test capture done");
        tally_and_finish();
    end
endmodule // cct_timer_bench
bind cct_timer cct_timer_asserts i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .output_disable_in,
    .timer_pin_out, .timer_pin_oe, .irq);
`default_nettype wire
